// ==== inc/fsr_cmd_if.sv ====
/*
  interface carrying decoded command bytes from the shifter to the register logic.
  assumes the shifter and the register logic share core_clk_i.
*/
`timescale 1ns/10ps
interface fsr_cmd_if;
  logic byte_valid;
  logic [7:0] byte_data;
  logic frame_end;
  logic on_boundary;
  logic [7:0] tx_byte;
  logic tx_load;
  modport shifter
  (
    output byte_valid,
    output byte_data,
    output frame_end,
    output on_boundary,
    input tx_byte,
    output tx_load
  );
  modport core
  (
    input byte_valid,
    input byte_data,
    input frame_end,
    input on_boundary,
    output tx_byte,
    input tx_load
  );
endinterface : fsr_cmd_if

// ==== inc/fsr_pkg.sv ====
/*
  package for the first flash status register: opcodes, bit positions,
  reset values and protection granule sizes.
  assumes nothing beyond a systemverilog compiler.
*/
package fsr_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_VOL_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] OP_WRITE_STATUS_ONE = 8'h01;
  localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] OP_IND_READ = 8'h65;
  localparam logic [7:0] OP_IND_WRITE = 8'h71;
  localparam logic [7:0] IND_ADDR_STATUS_ONE = 8'h01;
  localparam int BIT_LOCK_SEL_LO = 7;
  localparam int BIT_GRANULE = 6;
  localparam int BIT_DIRECTION = 5;
  localparam int BIT_EXTENT_HI = 4;
  localparam int BIT_EXTENT_LO = 2;
  localparam int BIT_WEL = 1;
  localparam int BIT_BUSY = 0;
  localparam logic [2:0] EXTENT_RESET = 3'h0;
  localparam logic [4:0] NV_RESET = 5'h00;
  localparam logic [16:0] GRANULE_64K = 17'h10000;
  localparam logic [16:0] GRANULE_4K = 17'h01000;
  localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
endpackage : fsr_pkg

// ==== logic/fsr_shifter.sv ====
/*
  serial byte shifter: gathers bits msb first while chip select is low and
  shifts out the byte offered by the register logic.
  assumes sck_rise_i and sck_fall_i are single-cycle strobes in core_clk_i.
*/
`timescale 1ns/10ps
module fsr_shifter
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_rise_i,
  input wire logic sck_fall_i,
  input wire logic si_i,
  output logic so_o,
  fsr_cmd_if.shifter cmd
);
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [6:0] shift_in;
  logic [6:0] next_shift_in;
  logic [7:0] shift_out;
  logic [7:0] next_shift_out;
  logic cs_d;
  logic next_cs_d;
  logic so;
  logic next_so;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_so = so;
    next_cs_d = cs_n_i;
    cmd.byte_valid = 1'b0;
    cmd.byte_data = {shift_in, si_i};
    cmd.frame_end = cs_n_i && !cs_d;
    cmd.on_boundary = (bit_cnt == 3'h0);
    cmd.tx_load = 1'b0;
    if (cs_n_i)
    begin
      next_bit_cnt = 3'h0;
      next_so = 1'b0;
    end
    else
    begin
      if (sck_rise_i)
      begin
        next_shift_in = {shift_in[5:0], si_i};
        next_bit_cnt = bit_cnt + 3'h1;
        if (bit_cnt == fsr_pkg::BIT_COUNT_LAST)
        begin
          cmd.byte_valid = 1'b1;
        end
      end
      if (sck_fall_i)
      begin
        // a fresh byte is loaded at each boundary so busy polling sees live state
        if (bit_cnt == 3'h0)
        begin
          cmd.tx_load = 1'b1;
          next_so = cmd.tx_byte[7];
          next_shift_out = {cmd.tx_byte[6:0], 1'b0};
        end
        else
        begin
          next_so = shift_out[7];
          next_shift_out = {shift_out[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_cnt <= 3'h0;
      shift_in <= 7'h00;
      shift_out <= 8'h00;
      cs_d <= 1'b1;
      so <= 1'b0;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      cs_d <= next_cs_d;
      so <= next_so;
    end
  end

  assign so_o = so;
endmodule : fsr_shifter

// ==== logic/fsr_status_one.sv ====
/*
  first status register of a serial flash with its command decode.
  assumes an external array controller reports busy and runs program/erase
  operations; the serial clock is sampled as strobes in core_clk_i.
*/
// Overview of operation
// - bit 7 with second lock bit and protect pin selects register write protection.
// - granule bit 0 gives 64 kB blocks, 1 gives 4 kB blocks.
// - direction bit 0 protects bottom up, 1 protects top down.
// - bits 4:2 pick protected extent; program or erase there is refused.
// - extent field resets to zero, nothing protected.
// - write status one command loads extent from its data byte.
// - with latch clear, program, erase and non-volatile status writes are rejected; volatile write enable still allows a flop-only status write.
// - latch clears on power-up and every device reset.
// - incomplete or unknown command abort leaves a set latch set.
// - abort clears latch only after a full modifying command was shifted.
// - write enable command sets the latch unless busy.
// - volatile write enable command leaves the latch unchanged.
// - busy bit 0 follows internal program or erase, read only.
// - read status one opcode shifts out current register byte.
// - volatile-enabled write updates flops only; write-enabled updates non-volatile copy too.
// - indirect read or write with address one reaches this register.
`timescale 1ns/10ps
module fsr_status_one
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_rise_i,
  input wire logic sck_fall_i,
  input wire logic si_i,
  output logic so_o,
  input wire logic write_protect_n_i,
  input wire logic status_lock_sel_hi_i,
  input wire logic array_busy_i,
  input wire logic modify_cmd_i,
  input wire logic [23:0] modify_addr_i,
  input wire logic [23:0] array_top_i,
  output logic modify_refused_o,
  output logic [4:0] nv_image_o,
  output logic nv_write_o
);
  typedef enum {
    FSR_IDLE,
    FSR_WRITE_DATA,
    FSR_IND_ADDR,
    FSR_IND_WRITE_ADDR,
    FSR_IND_WRITE_DATA,
    FSR_READOUT,
    FSR_MODIFY_SEEN,
    FSR_IGNORE
  } fsr_state_t;

  fsr_cmd_if cmd ();

  fsr_state_t state;
  fsr_state_t next_state;
  logic status_lock_sel_lo;
  logic next_status_lock_sel_lo;
  logic protect_granule_select;
  logic next_protect_granule_select;
  logic protect_direction;
  logic next_protect_direction;
  logic [2:0] protect_extent;
  logic [2:0] next_protect_extent;
  logic write_enable_latch;
  logic next_write_enable_latch;
  logic vol_enable;
  logic next_vol_enable;
  logic [4:0] nv_image;
  logic [4:0] next_nv_image;
  logic nv_write;
  logic next_nv_write;
  logic busy_d;
  logic next_busy_d;
  logic op_running;
  logic next_op_running;
  logic [7:0] status_byte;
  logic status_locked;
  logic [23:0] extent_bytes;
  logic [23:0] granule;
  logic in_region;

  fsr_shifter i_fsr_shifter
  (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i),
    .sck_rise_i(sck_rise_i),
    .sck_fall_i(sck_fall_i),
    .si_i(si_i),
    .so_o(so_o),
    .cmd(cmd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status byte and protection decode
  assign status_byte = {status_lock_sel_lo, protect_granule_select, protect_direction,
                        protect_extent, write_enable_latch, array_busy_i};
  assign cmd.tx_byte = status_byte;

  // locked when the hardware-protect scheme is chosen with the pin low, or lock bit hi set
  assign status_locked = status_lock_sel_hi_i ||
                         (status_lock_sel_lo && !write_protect_n_i);

  // extent 7 covers the whole array, 0 covers nothing; otherwise 2^(extent-1) granules
  assign granule = protect_granule_select ? {7'h00, fsr_pkg::GRANULE_4K}
                                          : {7'h00, fsr_pkg::GRANULE_64K};
  assign extent_bytes = (protect_extent == 3'h0) ? 24'h000000 :
                        (granule << (protect_extent - 3'h1));

  always_comb
  begin
    in_region = 1'b0;
    if (protect_extent == 3'h7)
    begin
      in_region = 1'b1;
    end
    else if (protect_extent != 3'h0)
    begin
      if (protect_direction)
      begin
        in_region = (modify_addr_i > (array_top_i - extent_bytes));
      end
      else
      begin
        in_region = (modify_addr_i < extent_bytes);
      end
    end
  end

  assign modify_refused_o = modify_cmd_i && (!write_enable_latch || in_region);

  ////////////////////////////////////////////////////////////////////////////
  // command sequencing
  always_comb
  begin
    next_state = state;
    next_status_lock_sel_lo = status_lock_sel_lo;
    next_protect_granule_select = protect_granule_select;
    next_protect_direction = protect_direction;
    next_protect_extent = protect_extent;
    next_write_enable_latch = write_enable_latch;
    next_vol_enable = vol_enable;
    next_nv_image = nv_image;
    next_nv_write = 1'b0;
    next_busy_d = array_busy_i;
    next_op_running = op_running;
    // completion clears first so a write enable landing in the same cycle wins
    if (op_running && busy_d && !array_busy_i)
    begin
      next_op_running = 1'b0;
      next_write_enable_latch = 1'b0;
    end
    if (modify_cmd_i && !modify_refused_o)
    begin
      next_op_running = 1'b1;
    end
    if (cmd.byte_valid)
    begin
      case (state)
        FSR_IDLE:
        begin
          if (cmd.byte_data == fsr_pkg::OP_WRITE_ENABLE)
          begin
            next_state = FSR_IGNORE;
            if (!array_busy_i)
            begin
              next_write_enable_latch = 1'b1;
              next_vol_enable = 1'b0;
            end
          end
          else if (cmd.byte_data == fsr_pkg::OP_VOL_WRITE_ENABLE)
          begin
            next_state = FSR_IGNORE;
            next_vol_enable = 1'b1;
          end
          else if (cmd.byte_data == fsr_pkg::OP_WRITE_STATUS_ONE)
          begin
            next_state = FSR_WRITE_DATA;
          end
          else if (cmd.byte_data == fsr_pkg::OP_IND_READ)
          begin
            next_state = FSR_IND_ADDR;
          end
          else if (cmd.byte_data == fsr_pkg::OP_IND_WRITE)
          begin
            next_state = FSR_IND_WRITE_ADDR;
          end
          else if (cmd.byte_data == fsr_pkg::OP_READ_STATUS_ONE)
          begin
            next_state = FSR_READOUT;
          end
          else
          begin
            next_state = FSR_IGNORE;
          end
        end
        FSR_IND_ADDR:
        begin
          // only a write opcode reaches the data phase; the read just streams out
          next_state = FSR_IGNORE;
          if (cmd.byte_data == fsr_pkg::IND_ADDR_STATUS_ONE)
          begin
            next_state = FSR_READOUT;
          end
        end
        FSR_IND_WRITE_ADDR:
        begin
          next_state = FSR_IGNORE;
          if (cmd.byte_data == fsr_pkg::IND_ADDR_STATUS_ONE)
          begin
            next_state = FSR_IND_WRITE_DATA;
          end
        end
        FSR_WRITE_DATA, FSR_IND_WRITE_DATA:
        begin
          next_state = FSR_IGNORE;
          if ((write_enable_latch || vol_enable) && !status_locked && !array_busy_i)
          begin
            next_status_lock_sel_lo = cmd.byte_data[fsr_pkg::BIT_LOCK_SEL_LO];
            next_protect_granule_select = cmd.byte_data[fsr_pkg::BIT_GRANULE];
            next_protect_direction = cmd.byte_data[fsr_pkg::BIT_DIRECTION];
            next_protect_extent =
              cmd.byte_data[fsr_pkg::BIT_EXTENT_HI:fsr_pkg::BIT_EXTENT_LO];
            if (!vol_enable)
            begin
              next_nv_image = cmd.byte_data[7:3];
              next_nv_write = 1'b1;
              next_write_enable_latch = 1'b0;
            end
            next_vol_enable = 1'b0;
          end
          else if (write_enable_latch)
          begin
            // full command shifted while writes are barred still consumes the latch
            next_state = FSR_MODIFY_SEEN;
          end
        end
        default:
        begin
          next_state = state;
        end
      endcase
    end
    if (cmd.frame_end)
    begin
      // an abort mid-command keeps the latch: only whole modifying commands clear it
      if (state == FSR_MODIFY_SEEN)
      begin
        next_write_enable_latch = 1'b0;
      end
      next_state = FSR_IDLE;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= FSR_IDLE;
      status_lock_sel_lo <= 1'b0;
      protect_granule_select <= 1'b0;
      protect_direction <= 1'b0;
      protect_extent <= fsr_pkg::EXTENT_RESET;
      write_enable_latch <= 1'b0;
      vol_enable <= 1'b0;
      nv_image <= fsr_pkg::NV_RESET;
      nv_write <= 1'b0;
      busy_d <= 1'b0;
      op_running <= 1'b0;
    end
    else
    begin
      state <= next_state;
      status_lock_sel_lo <= next_status_lock_sel_lo;
      protect_granule_select <= next_protect_granule_select;
      protect_direction <= next_protect_direction;
      protect_extent <= next_protect_extent;
      write_enable_latch <= next_write_enable_latch;
      vol_enable <= next_vol_enable;
      nv_image <= next_nv_image;
      nv_write <= next_nv_write;
      busy_d <= next_busy_d;
      op_running <= next_op_running;
    end
  end

  assign nv_image_o = nv_image;
  assign nv_write_o = nv_write;
endmodule : fsr_status_one

// ==== verification/fsr_spi_host.sv ====
/*
  serial host model: frames msb-first bytes on serial clock strobes.
  assumes strobes are sampled on rising edges of core_clk_i.
*/
`timescale 1ns/10ps
module fsr_spi_host
(
  input wire logic core_clk_i,
  input wire logic so_i,
  output logic cs_n_o,
  output logic sck_rise_o,
  output logic sck_fall_o,
  output logic si_o
);
  initial
  begin
    cs_n_o = 1'b1;
    sck_rise_o = 1'b0;
    sck_fall_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask : tick
  // so is taken at the rise that samples si
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck_fall_o = 1'b1;
      tick();
      sck_fall_o = 1'b0;
      si_o = tx[i];
      tick();
      sck_rise_o = 1'b1;
      rx[i] = so_i;
      tick();
      sck_rise_o = 1'b0;
    end
  endtask : xbyte
  // si flips between frames so a stale level is never mistaken for data
  task automatic frame(input int n, input logic [23:0] b, output logic [7:0] rx);
    cs_n_o = 1'b0;
    tick();
    for (int k = 0; k < n; k++)
      xbyte(b[23 - 8 * k -: 8], rx);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    tick();
    tick();
  endtask : frame
  task automatic poll(output logic [7:0] rx);
    cs_n_o = 1'b0;
    tick();
    xbyte(8'h05, rx);
    rx = 8'hFF;
    for (int k = 0; k < 40 && rx[0] !== 1'b0; k++)
      xbyte(8'h00, rx);
    cs_n_o = 1'b1;
    tick();
    tick();
  endtask : poll
endmodule : fsr_spi_host

// ==== verification/fsr_status_one_checker.sv ====
/*
  port assertions for the first flash status register.
  assumes one core clock and the async active-low reset of fsr_status_one.
*/
`timescale 1ns/10ps
module fsr_status_one_checker
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_rise_i,
  input wire logic sck_fall_i,
  input wire logic status_lock_sel_hi_i,
  input wire logic modify_cmd_i,
  input wire logic so_o,
  input wire logic modify_refused_o,
  input wire logic nv_write_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic any_frame;
  logic next_any_frame;
  // until the first frame the latch can only be clear
  always_comb
  begin
    next_any_frame = any_frame | ~cs_n_i;
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      any_frame <= 1'b0;
    else
      any_frame <= next_any_frame;
  end
  ////////////////////////////////////////
  sequence s_quiet;
    !cs_n_i && !sck_fall_i ##1 !cs_n_i;
  endsequence
  property p_so_hold;
    s_quiet |-> $stable(so_o);
  endproperty
  a_so_hold: assert property (p_so_hold) else $error("so moved");
  property p_so_idle;
    cs_n_i && $past(cs_n_i) |-> !so_o;
  endproperty
  a_so_idle: assert property (p_so_idle) else $error("so idle");
  property p_nv_pulse;
    nv_write_o |=> !nv_write_o;
  endproperty
  a_nv_pulse: assert property (p_nv_pulse) else $error("nv pulse");
  property p_nv_rise;
    nv_write_o |-> $past(sck_rise_i) || $past(sck_rise_i, 2) || $past(sck_rise_i, 3);
  endproperty
  a_nv_rise: assert property (p_nv_rise) else $error("nv cause");
  property p_nv_idle;
    cs_n_i [*6] |-> !nv_write_o;
  endproperty
  a_nv_idle: assert property (p_nv_idle) else $error("nv idle");
  property p_refused_cmd;
    modify_refused_o |-> modify_cmd_i;
  endproperty
  a_refused_cmd: assert property (p_refused_cmd) else $error("refuse");
  property p_fresh;
    !any_frame && modify_cmd_i |-> modify_refused_o;
  endproperty
  a_fresh: assert property (p_fresh) else $error("latch at reset");
  property p_lock;
    status_lock_sel_hi_i [*8] |-> !nv_write_o;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write");
endmodule : fsr_status_one_checker
bind fsr_status_one fsr_status_one_checker i_fsr_status_one_checker
(
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sck_rise_i(sck_rise_i),
  .sck_fall_i(sck_fall_i), .status_lock_sel_hi_i(status_lock_sel_hi_i),
  .modify_cmd_i(modify_cmd_i), .so_o(so_o), .modify_refused_o(modify_refused_o),
  .nv_write_o(nv_write_o)
);

// ==== verification/fsr_status_one_tb_top.sv ====
/*
  self-checking bench: host model frames, pins and array side driven here.
  assumes the checker binds itself to fsr_status_one.
*/
`timescale 1ns/10ps
module fsr_status_one_tb_top;
  logic clk, rst_n, cs_n, sck_rise, sck_fall, si, so, wp_n, lock_hi, busy;
  logic mod_cmd, refused, nv_write;
  logic [23:0] mod_addr;
  logic [4:0] nv_image, nv_seen;
  logic [7:0] rx, nv_count;
  int fails, n_tests;
  fsr_status_one i_fsr_status_one (.core_clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n),
    .sck_rise_i(sck_rise), .sck_fall_i(sck_fall), .si_i(si), .so_o(so),
    .write_protect_n_i(wp_n), .status_lock_sel_hi_i(lock_hi), .array_busy_i(busy),
    .modify_cmd_i(mod_cmd), .modify_addr_i(mod_addr), .array_top_i(24'h0FFFFF),
    .modify_refused_o(refused), .nv_image_o(nv_image), .nv_write_o(nv_write));
  fsr_spi_host i_fsr_spi_host (.core_clk_i(clk), .so_i(so), .cs_n_o(cs_n),
    .sck_rise_o(sck_rise), .sck_fall_o(sck_fall), .si_o(si));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      nv_count <= 8'h00;
      nv_seen <= 5'h00;
    end
    else if (nv_write === 1'b1)
    begin
      nv_count <= nv_count + 8'h01;
      nv_seen <= nv_image;
    end
  end
  ////////////////////////////////////////
  task automatic results();
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8
  task automatic cmd(input logic [7:0] op);
    i_fsr_spi_host.frame(1, {op, 16'h0000}, rx);
  endtask : cmd
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    cmd(op);
    i_fsr_spi_host.frame(2, {8'h01, d, 8'h00}, rx);
  endtask : wr
  task automatic rd(input logic [7:0] exp);
    i_fsr_spi_host.frame(2, 24'h050000, rx);
    cmp8("status", exp, rx);
  endtask : rd
  // refusal is combinational, so it is looked at inside the request cycle
  task automatic mod(input logic [23:0] a, input logic exp);
    mod_addr = a;
    mod_cmd = 1'b1;
    #1;
    cmp8("refused", {7'h00, exp}, {7'h00, refused});
    @(posedge clk);
    #1;
    mod_cmd = 1'b0;
    @(posedge clk);
    #1;
  endtask : mod
  ////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
  initial
  begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    lock_hi = 1'b0;
    busy = 1'b0;
    mod_cmd = 1'b0;
    mod_addr = 24'h000000;
    fails = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    mod(24'h000000, 1'b1);
    rd(8'h00);
    cmd(8'h06);
    rd(8'h02);
    cmd(8'hFF);
    rd(8'h02);
    wr(8'h06, 8'h4C);
    rd(8'h4C);
    cmp8("nv image", 8'h09, {3'h0, nv_seen});
    cmd(8'h50);
    rd(8'h4C);
    wr(8'h50, 8'h44);
    cmp8("nv count", 8'h01, nv_count);
    i_fsr_spi_host.frame(3, 24'h650100, rx);
    cmp8("indirect", 8'h44, rx);
    cmd(8'h06);
    mod(24'h000FFF, 1'b1);
    mod(24'h001000, 1'b0);
    busy = 1'b1;
    rd(8'h47);
    fork
      begin
        repeat (60) @(posedge clk);
        #1;
        busy = 1'b0;
      end
      i_fsr_spi_host.poll(rx);
    join
    cmp8("busy", 8'h00, {7'h00, rx[0]});
    rd(8'h44);
    wr(8'h50, 8'h64);
    cmd(8'h06);
    mod(24'h0FF000, 1'b1);
    mod(24'h0FEFFF, 1'b0);
    wr(8'h50, 8'h1C);
    mod(24'h0FFFFF, 1'b1);
    lock_hi = 1'b1;
    wr(8'h06, 8'h00);
    rd(8'h1C);
    lock_hi = 1'b0;
    wr(8'h50, 8'h9C);
    wp_n = 1'b0;
    wr(8'h06, 8'h00);
    rd(8'h9C);
    wp_n = 1'b1;
    cmd(8'h50);
    i_fsr_spi_host.frame(3, 24'h710104, rx);
    rd(8'h04);
    cmd(8'h06);
    mod(24'h00FFFF, 1'b1);
    mod(24'h010000, 1'b0);
    // mid-run reset with the latch set must bring everything back to zero
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(8'h00);
    mod(24'h000000, 1'b1);
    results();
  end
endmodule : fsr_status_one_tb_top
